/* File: bsc_pkg.sv */
// package: timing constants, crc constants and enums for the bit slot and crc engine
package bsc_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_MHZ           = 20;
   localparam int RESET_LOW_MIN_US  = 480;
   localparam int RESET_LOW_CNT     = RESET_LOW_MIN_US * CLK_MHZ;
   localparam int POR_LOW_MS        = 5;
   localparam int POR_LOW_CNT       = POR_LOW_MS * 1000 * CLK_MHZ;
   localparam int PRES_WAIT_US      = 30;
   localparam int PRES_WAIT_CNT     = PRES_WAIT_US * CLK_MHZ;
   localparam int PRES_LOW_US       = 120;
   localparam int PRES_LOW_CNT      = PRES_LOW_US * CLK_MHZ;
   localparam int SAMPLE_US         = 30;
   localparam int SAMPLE_CNT        = SAMPLE_US * CLK_MHZ;
   localparam int READ_VALID_US     = 15;
   localparam int READ_HOLD_US      = 30;
   localparam int READ_HOLD_CNT     = READ_HOLD_US * CLK_MHZ;
   localparam int TIMER_W           = 24;

   // ****************************************************************
   // crc
   // ****************************************************************
   localparam logic [7:0]  CRC8_POLY_REV  = 8'h8c;
   localparam logic [15:0] CRC16_POLY_REV = 16'ha001;
   localparam logic [15:0] CRC16_CLEAR    = 16'h0000;
   localparam logic [7:0]  CRC8_CLEAR     = 8'h00;

   // ****************************************************************
   // crc operations requested by the command layer
   // ****************************************************************
   typedef enum logic [2:0] {
      BSC_OP_NONE  = 3'b000,
      BSC_OP_CLEAR = 3'b001,
      BSC_OP_SHIFT = 3'b010,
      BSC_OP_LOAD  = 3'b011,
      BSC_OP_CSHFT = 3'b100
   } bsc_op_t;

   // channel access crc insertion choice
   typedef enum logic [1:0] {
      BSC_INS_NONE = 2'b00,
      BSC_INS_1    = 2'b01,
      BSC_INS_8    = 2'b10,
      BSC_INS_32   = 2'b11
   } bsc_ins_t;

   typedef enum logic [2:0] {
      BSC_IDLE    = 3'b000,
      BSC_RST_LOW = 3'b001,
      BSC_PWAIT   = 3'b010,
      BSC_PRES    = 3'b011,
      BSC_SLOT    = 3'b100,
      BSC_PROG    = 3'b101
   } bsc_state_t;

endpackage

/* File: bsc_buf2.sv */
// two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module bsc_buf2 (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] in_data_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   output logic [7:0]      out_data_o,
   output logic            out_valid_o,
   input  wire logic       out_ready_i
);
   logic [7:0] mem [2];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;
   logic       push;
   logic       pop;

   assign push        = in_valid_i && (count != 2'h2);
   assign pop         = out_valid_o && out_ready_i;
   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = mem[rd_ptr];

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule

/* File: bsc_engine.sv */
// bit slot timing, reset/presence, program pulse detect and crc8/crc16 engines
// How it works
// - presence after 15-60us wait, 60-240us long
// - reset low over 5ms causes power-on reset
// - falling edge starts the slot delay timer
// - write slot sampled at fixed timer point
// - read zero held low, read one released
// - program pulse copies scratchpad into eprom byte
// - crc8 x8+x5+x4+1 over first 56 id bits
// - crc16 x16+x15+x2+1 sent complemented
// - memory read: clear, command, address, all bytes
// - status read: same seeding, crc after page
// - extended read first pass covers cmd, addr, redirect
// - later extended passes cover redirect byte only
// - page end crc covers only page data
// - first write byte crc: cmd, address, data
// - later write bytes load address then shift
// - channel crc insertion: none, 1, 8, 32
// - first channel crc: cmd, controls, info, data
// - later channel crcs cover only new block
// - crc mismatch never blocks a command
`timescale 1ns/1ps
module bsc_engine
   import bsc_pkg::*;
#(
   parameter int RESET_LOW_CYC = RESET_LOW_CNT,
   parameter int POR_LOW_CYC   = POR_LOW_CNT
) (
   input  wire logic            ref_clk_i,
   input  wire logic            reset_i,
   input  wire logic            line_i,
   output logic                 line_o,
   output logic                 line_oe_n_o,
   input  wire logic            prog_pulse_i,
   input  wire logic            tx_bit_i,
   input  wire logic            tx_mode_i,
   output logic                 tx_bit_ack_o,
   output logic [7:0]           rx_data_o,
   output logic                 rx_valid_o,
   input  wire logic            rx_ready_i,
   output logic                 rx_stall_o,
   output logic                 bus_reset_o,
   output logic                 power_on_reset_o,
   output logic                 prog_strobe_o,
   input  wire bsc_pkg::bsc_op_t crc_op_i,
   input  wire logic [7:0]      crc_byte_i,
   input  wire logic [15:0]     crc_load_i,
   input  wire logic            crc8_clear_i,
   input  wire logic            crc8_shift_i,
   input  wire bsc_pkg::bsc_ins_t ins_mode_i,
   input  wire logic            ins_block_start_i,
   input  wire logic            ins_data_byte_i,
   output logic                 crc_due_o,
   output logic [15:0]          crc16_o,
   output logic [15:0]          crc16_tx_o,
   output logic [7:0]           crc8_o
);

   // ****************************************************************
   // crc helpers
   // ****************************************************************
   // lsb first on the line, so the reflected polynomials are used
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC16_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC8_POLY_REV) : (r >> 1);
      end
      return r;
   endfunction

   // ****************************************************************
   // line edge detection
   // ****************************************************************
   logic       line_q;
   logic       fall;
   logic       rise;
   bsc_state_t state;
   logic [TIMER_W-1:0] timer;
   logic       drive_low;
   logic [2:0] bit_idx;
   logic [7:0] shreg;
   logic       byte_done;
   logic       buf_ready;
   logic [7:0] buf_data;
   logic       buf_valid;
   logic       prog_q;

   assign fall = line_q && !line_i;
   assign rise = !line_q && line_i;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         line_q <= 1'b1;
         prog_q <= 1'b0;
      end else begin
         line_q <= line_i;
         prog_q <= prog_pulse_i;
      end
   end

   // ****************************************************************
   // slot, reset and presence sequencing
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= BSC_IDLE;
         timer <= '0;
      end else begin
         unique case (state)
            BSC_IDLE: begin
               if (prog_pulse_i && !prog_q) begin
                  state <= BSC_PROG;
               end else if (fall) begin
                  state <= BSC_SLOT;
                  timer <= '0;
               end
            end
            BSC_SLOT: begin
               timer <= timer + 1'b1;
               if (line_i && timer > TIMER_W'(READ_HOLD_CNT)) begin
                  state <= BSC_IDLE;
               // timer reads two behind the low-sample count: fall is seen one late
               end else if (!line_i && timer >= TIMER_W'(RESET_LOW_CYC - 2)) begin
                  state <= BSC_RST_LOW;
               end
            end
            BSC_RST_LOW: begin
               timer <= timer + 1'b1;
               if (rise) begin
                  state <= BSC_PWAIT;
                  timer <= '0;
               end
            end
            BSC_PWAIT: begin
               timer <= timer + 1'b1;
               if (timer == TIMER_W'(PRES_WAIT_CNT - 1)) begin
                  state <= BSC_PRES;
                  timer <= '0;
               end
            end
            BSC_PRES: begin
               timer <= timer + 1'b1;
               if (timer == TIMER_W'(PRES_LOW_CNT - 1)) begin
                  state <= BSC_IDLE;
                  timer <= '0;
               end
            end
            BSC_PROG: begin
               if (!prog_pulse_i) begin
                  state <= BSC_IDLE;
               end
            end
            default: begin
               state <= BSC_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // power-on reset on an over-long low
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         power_on_reset_o <= 1'b0;
         bus_reset_o      <= 1'b0;
      end else begin
         power_on_reset_o <= (state == BSC_RST_LOW) && !line_i
                             && (timer == TIMER_W'(POR_LOW_CYC - 2));
         bus_reset_o      <= (state == BSC_RST_LOW) && rise;
      end
   end

   // ****************************************************************
   // bit transfer and line drive
   // ****************************************************************
   // a read zero is released well before the slot ends so recovery stays possible
   always_comb begin
      drive_low = 1'b0;
      if (state == BSC_PRES) begin
         drive_low = 1'b1;
      end else if (state == BSC_SLOT && tx_mode_i && !tx_bit_i
                   && timer < TIMER_W'(READ_HOLD_CNT)) begin
         drive_low = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         line_o      <= 1'b0;
         line_oe_n_o <= 1'b1;
      end else begin
         line_o      <= 1'b0;
         line_oe_n_o <= !drive_low;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bit_idx      <= 3'h0;
         shreg        <= 8'h00;
         byte_done    <= 1'b0;
         tx_bit_ack_o <= 1'b0;
      end else begin
         byte_done    <= 1'b0;
         tx_bit_ack_o <= 1'b0;
         if (bus_reset_o) begin
            bit_idx <= 3'h0;
         end else if (state == BSC_SLOT && timer == TIMER_W'(SAMPLE_CNT)) begin
            if (tx_mode_i) begin
               tx_bit_ack_o <= 1'b1;
            end else begin
               shreg   <= {line_i, shreg[7:1]};
               bit_idx <= bit_idx + 3'h1;
               if (bit_idx == 3'h7) begin
                  byte_done <= 1'b1;
               end
            end
         end
      end
   end

   bsc_buf2 u_buf (
      .ref_clk_i  (ref_clk_i),
      .reset_i    (reset_i),
      .in_data_i  (shreg),
      .in_valid_i (byte_done),
      .in_ready_o (buf_ready),
      .out_data_o (buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(rx_ready_i && !rx_valid_o)
   );

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_stall_o <= 1'b0;
      end else begin
         rx_stall_o <= !buf_ready;
         if (rx_valid_o) begin
            rx_valid_o <= 1'b0;
         end else if (buf_valid && rx_ready_i) begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= buf_data;
         end
      end
   end

   // ****************************************************************
   // program pulse
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_strobe_o <= 1'b0;
      end else begin
         prog_strobe_o <= (state == BSC_PROG) && !prog_pulse_i;
      end
   end

   // ****************************************************************
   // crc generators
   // ****************************************************************
   // no compare here: mismatches never stall the command flow
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         crc16_o <= CRC16_CLEAR;
      end else begin
         unique case (crc_op_i)
            BSC_OP_CLEAR: crc16_o <= CRC16_CLEAR;
            BSC_OP_SHIFT: crc16_o <= crc16_byte(crc16_o, crc_byte_i);
            BSC_OP_LOAD:  crc16_o <= crc_load_i;
            BSC_OP_CSHFT: crc16_o <= crc16_byte(CRC16_CLEAR, crc_byte_i);
            default:      crc16_o <= crc16_o;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         crc16_tx_o <= ~CRC16_CLEAR;
      end else begin
         crc16_tx_o <= ~crc16_o;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         crc8_o <= CRC8_CLEAR;
      end else if (crc8_clear_i) begin
         crc8_o <= CRC8_CLEAR;
      end else if (crc8_shift_i) begin
         crc8_o <= crc8_byte(crc8_o, crc_byte_i);
      end
   end

   // ****************************************************************
   // channel access crc insertion
   // ****************************************************************
   logic [5:0] ins_cnt;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ins_cnt   <= 6'h00;
         crc_due_o <= 1'b0;
      end else begin
         crc_due_o <= 1'b0;
         if (ins_block_start_i) begin
            ins_cnt <= 6'h00;
         end else if (ins_data_byte_i) begin
            unique case (ins_mode_i)
               BSC_INS_NONE: ins_cnt <= 6'h00;
               BSC_INS_1: begin
                  crc_due_o <= 1'b1;
               end
               BSC_INS_8: begin
                  crc_due_o <= (ins_cnt == 6'h07);
                  ins_cnt   <= (ins_cnt == 6'h07) ? 6'h00 : ins_cnt + 6'h01;
               end
               BSC_INS_32: begin
                  crc_due_o <= (ins_cnt == 6'h1f);
                  ins_cnt   <= (ins_cnt == 6'h1f) ? 6'h00 : ins_cnt + 6'h01;
               end
            endcase
         end
      end
   end

endmodule

/* File: bsc_engine_checker.sv */
// checker: concurrent assertions on the slot and crc engine ports
`timescale 1ns/1ps
module bsc_engine_checker
   import bsc_pkg::*;
#(
   parameter int RESET_LOW_CYC = RESET_LOW_CNT,
   parameter int POR_LOW_CYC   = POR_LOW_CNT
) (
   input wire logic              ref_clk_i,
   input wire logic              reset_i,
   input wire logic              line_i,
   input wire logic              line_oe_n_o,
   input wire logic              prog_pulse_i,
   input wire logic              tx_bit_i,
   input wire logic              tx_mode_i,
   input wire logic              rx_valid_o,
   input wire logic              bus_reset_o,
   input wire logic              prog_strobe_o,
   input wire bsc_pkg::bsc_op_t  crc_op_i,
   input wire logic [15:0]       crc_load_i,
   input wire logic              crc8_clear_i,
   input wire logic              crc8_shift_i,
   input wire bsc_pkg::bsc_ins_t ins_mode_i,
   input wire logic              crc_due_o,
   input wire logic [15:0]       crc16_o,
   input wire logic [15:0]       crc16_tx_o,
   input wire logic [7:0]        crc8_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // ****************************************************************
   // helper counters
   // ****************************************************************
   // long windows are counted here: delay ranges that wide would not unroll
   logic        pres_pending;
   logic [12:0] wait_cnt;
   logic [12:0] low_cnt;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pres_pending <= 1'b0;
         wait_cnt     <= 13'h0000;
         low_cnt      <= 13'h0000;
      end else begin
         if (bus_reset_o) begin
            pres_pending <= 1'b1;
            wait_cnt     <= 13'h0000;
         end else if (!line_oe_n_o) begin
            pres_pending <= 1'b0;
         end else if (pres_pending && wait_cnt != 13'h1fff) begin
            wait_cnt <= wait_cnt + 13'h0001;
         end
         if (line_oe_n_o) begin
            low_cnt <= 13'h0000;
         end else if (low_cnt != 13'h1fff) begin
            low_cnt <= low_cnt + 13'h0001;
         end
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   pres_wait_a: assert property (pres_pending && $fell(line_oe_n_o) |-> wait_cnt >= 13'h012c)
      else $error("presence start too early");
   pres_due_a: assert property (pres_pending |-> wait_cnt <= 13'h04b0)
      else $error("presence start too late");
   // read zero is about 600 cycles, presence far longer but bounded
   pres_len_a: assert property ($rose(line_oe_n_o) |-> low_cnt >= 13'h01f4)
      else $error("line low too short");
   low_max_a: assert property (!line_oe_n_o |-> low_cnt < 13'h12c0)
      else $error("line held low too long");
   read_zero_a: assert property (tx_mode_i && !tx_bit_i && $fell(line_i) |-> ##[1:4] !line_oe_n_o)
      else $error("read zero not driven");
   crc_inv_a: assert property (crc16_tx_o == ~$past(crc16_o))
      else $error("sent crc not complement");
   crc_clear_a: assert property (crc_op_i == BSC_OP_CLEAR |=> crc16_o == 16'h0000)
      else $error("crc not cleared");
   crc_load_a: assert property (crc_op_i == BSC_OP_LOAD |=> crc16_o == $past(crc_load_i))
      else $error("crc load wrong");
   crc8_clr_a: assert property (crc8_clear_i && !crc8_shift_i |=> crc8_o == 8'h00)
      else $error("crc8 not cleared");
   prog_stb_a: assert property ($fell(prog_pulse_i) |-> ##[1:4] prog_strobe_o)
      else $error("no copy strobe after program pulse");
   rx_gap_a: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("rx valid longer than one cycle");
   no_ins_a: assert property ((ins_mode_i == BSC_INS_NONE) [*2] |-> !crc_due_o)
      else $error("crc due with insertion off");
endmodule

bind bsc_engine bsc_engine_checker #(
   .RESET_LOW_CYC (RESET_LOW_CYC),
   .POR_LOW_CYC   (POR_LOW_CYC)
) u_bsc_engine_checker (.*);

/* File: bsc_master_model.sv */
// single-wire bus master model with pull-up line resolution
`timescale 1ns/1ps
module bsc_master_model (
   input  wire logic ref_clk_i,
   input  wire logic dev_line_i,
   input  wire logic dev_oe_n_i,
   output logic      line_o,
   output logic      prog_o
);
   logic master_low = 1'b0;
   initial prog_o = 1'b0;
   // pull-up wins unless a party pulls low
   assign line_o = !(master_low || (!dev_oe_n_i && !dev_line_i));
   task automatic hold(input logic low, input int n);
      master_low <= low;
      repeat (n) @(posedge ref_clk_i);
   endtask
   // reset low, kept short of the limits
   task automatic bus_reset(input int n, output int pwait, output int plen);
      pwait = 0;
      plen = 0;
      hold(1'b1, n);
      hold(1'b0, 1);
      while (line_o && pwait < 2000) begin
         @(posedge ref_clk_i);
         pwait++;
      end
      while (!line_o && plen < 6000) begin
         @(posedge ref_clk_i);
         plen++;
      end
      hold(1'b0, 100);
   endtask
   // every slot opens with a fall
   task automatic write_bit(input logic b);
      hold(1'b1, b ? 20 : 1300);
      hold(1'b0, b ? 1380 : 100);
   endtask
   task automatic write_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) write_bit(v[i]);
   endtask
   // sample late but inside the read valid window
   task automatic read_bit(output logic b);
      hold(1'b1, 20);
      hold(1'b0, 260);
      b = line_o;
      hold(1'b0, 1120);
   endtask
   task automatic prog(input int n);
      prog_o <= 1'b1;
      repeat (n) @(posedge ref_clk_i);
      prog_o <= 1'b0;
      @(posedge ref_clk_i);
   endtask
endmodule

/* File: test_bit_slot_and_crc16_engine.sv */
// testbench: slot, buffer and crc scenarios for the slot and crc engine
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_bit_slot_and_crc16_engine;
   import bsc_pkg::*;
   // write-zero slots hold the line low 1300 cycles, so the scaled reset stays above that
   localparam int RST_CYC = 2000;
   localparam int POR_CYC = 4000;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        line, dev_line, oe_n, prog, tx_bit, tx_mode, ack, rx_valid, rx_ready, stall;
   logic        bres, por, pstb, c8clr, c8sh, ins_start, ins_byte, due;
   logic [7:0]  rx_data, crc_byte, crc8;
   logic [15:0] crc_load, crc16, crc16_tx;
   bsc_op_t     crc_op;
   bsc_ins_t    ins_mode;
   int          miscompares = 0;
   int          check_count = 0;
   int          n_bres = 0, n_por = 0, n_pstb = 0, n_due = 0, n_ack = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   bsc_engine #(.RESET_LOW_CYC(RST_CYC), .POR_LOW_CYC(POR_CYC)) u_bsc_engine (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .line_i(line), .line_o(dev_line),
      .line_oe_n_o(oe_n), .prog_pulse_i(prog), .tx_bit_i(tx_bit), .tx_mode_i(tx_mode),
      .tx_bit_ack_o(ack), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
      .rx_stall_o(stall), .bus_reset_o(bres), .power_on_reset_o(por), .prog_strobe_o(pstb),
      .crc_op_i(crc_op), .crc_byte_i(crc_byte), .crc_load_i(crc_load),
      .crc8_clear_i(c8clr), .crc8_shift_i(c8sh), .ins_mode_i(ins_mode),
      .ins_block_start_i(ins_start), .ins_data_byte_i(ins_byte), .crc_due_o(due),
      .crc16_o(crc16), .crc16_tx_o(crc16_tx), .crc8_o(crc8));

   bsc_master_model u_bsc_master_model (.ref_clk_i(ref_clk_i), .dev_line_i(dev_line),
      .dev_oe_n_i(oe_n), .line_o(line), .prog_o(prog));

   // pulses are counted here so no scenario can miss a one-cycle strobe
   always @(posedge ref_clk_i) begin
      n_bres += bres;
      n_por += por;
      n_pstb += pstb;
      n_due += due;
      n_ack += ack;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] fcrc(input logic [15:0] c, input logic [7:0] b,
                                        input logic [15:0] p);
      for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? p : 16'h0000);
      return c;
   endfunction

   task automatic op(input bsc_op_t o, input logic [7:0] b);
      crc_op <= o;
      crc_byte <= b;
      @(posedge ref_clk_i);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_presence();
      int w, l;
      u_bsc_master_model.bus_reset(RST_CYC, w, l);
      `CHK(n_bres > 0, 1'b1)
      `CHK(w >= 300 && w <= 1200, 1'b1)
      `CHK(l >= 1200 && l <= 4800, 1'b1)
      $display("test presence done");
   endtask

   task automatic t_buffer();
      logic [7:0] got [2];
      int k;
      k = 0;
      rx_ready <= 1'b0;
      u_bsc_master_model.write_byte(8'ha5);
      u_bsc_master_model.write_byte(8'h3c);
      `CHK(stall, 1'b1)
      rx_ready <= 1'b1;
      for (int i = 0; i < 40 && k < 2; i++) begin
         @(posedge ref_clk_i);
         if (rx_valid === 1'b1) begin
            got[k] = rx_data;
            k++;
         end
      end
      `CHK(k, 2)
      if (k < 2) wrap_up();
      `CHK(got[0], 8'ha5)
      `CHK(got[1], 8'h3c)
      $display("test buffer done");
   endtask

   task automatic t_read();
      logic b;
      int k;
      k = n_ack;
      tx_mode <= 1'b1;
      tx_bit <= 1'b0;
      u_bsc_master_model.read_bit(b);
      `CHK(b, 1'b0)
      tx_bit <= 1'b1;
      u_bsc_master_model.read_bit(b);
      `CHK(b, 1'b1)
      `CHK(n_ack - k, 2)
      tx_mode <= 1'b0;
      $display("test read done");
   endtask

   task automatic t_prog();
      int k;
      k = n_pstb;
      u_bsc_master_model.prog(9600);
      repeat (6) @(posedge ref_clk_i);
      `CHK(n_pstb - k, 1)
      $display("test prog done");
   endtask

   task automatic t_crc();
      logic [15:0] e;
      e = fcrc(fcrc(fcrc(fcrc(16'h0000, 8'hf0, 16'ha001), 8'h12, 16'ha001), 8'h00,
               16'ha001), 8'h5a, 16'ha001);
      op(BSC_OP_SHIFT, 8'h77);
      op(BSC_OP_CSHFT, 8'hf0);
      op(BSC_OP_SHIFT, 8'h12);
      op(BSC_OP_SHIFT, 8'h00);
      op(BSC_OP_SHIFT, 8'h5a);
      op(BSC_OP_NONE, 8'h00);
      op(BSC_OP_NONE, 8'h00);
      `CHK(crc16, e)
      `CHK(crc16_tx, ~e)
      crc_load <= 16'h0013;
      op(BSC_OP_LOAD, 8'h00);
      op(BSC_OP_SHIFT, 8'hc3);
      op(BSC_OP_NONE, 8'h00);
      `CHK(crc16, fcrc(16'h0013, 8'hc3, 16'ha001))
      op(BSC_OP_CLEAR, 8'h00);
      op(BSC_OP_SHIFT, 8'h81);
      op(BSC_OP_NONE, 8'h00);
      `CHK(crc16, fcrc(16'h0000, 8'h81, 16'ha001))
      c8sh <= 1'b1;
      crc_byte <= 8'hff;
      @(posedge ref_clk_i);
      c8sh <= 1'b0;
      c8clr <= 1'b1;
      @(posedge ref_clk_i);
      c8clr <= 1'b0;
      e = 16'h0000;
      for (int i = 1; i <= 7; i++) begin
         c8sh <= 1'b1;
         crc_byte <= 8'(i * 37);
         e = fcrc(e, 8'(i * 37), 16'h008c);
         @(posedge ref_clk_i);
      end
      c8sh <= 1'b0;
      @(posedge ref_clk_i);
      `CHK(crc8, e[7:0])
      $display("test crc done");
   endtask

   task automatic t_ins();
      int k;
      int exp_due [4] = '{0, 32, 4, 1};
      for (int m = 0; m < 4; m++) begin
         ins_mode <= bsc_ins_t'(m[1:0]);
         ins_start <= 1'b1;
         @(posedge ref_clk_i);
         ins_start <= 1'b0;
         k = n_due;
         repeat (32) begin
            ins_byte <= 1'b1;
            @(posedge ref_clk_i);
            ins_byte <= 1'b0;
            @(posedge ref_clk_i);
         end
         repeat (3) @(posedge ref_clk_i);
         `CHK(n_due - k, exp_due[m])
      end
      $display("test insertion done");
   endtask

   task automatic t_por();
      int k;
      k = n_por;
      u_bsc_master_model.hold(1'b1, POR_CYC + 20);
      u_bsc_master_model.hold(1'b0, 4000);
      `CHK(n_por > k, 1'b1)
      $display("test power on done");
   endtask

   initial begin
      {tx_bit, tx_mode, c8clr, c8sh, ins_start, ins_byte} = '0;
      rx_ready = 1'b1;
      crc_op = BSC_OP_NONE;
      crc_byte = 8'h00;
      crc_load = 16'h0000;
      ins_mode = BSC_INS_NONE;
      repeat (20) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      t_presence();
      t_buffer();
      t_read();
      t_prog();
      t_crc();
      t_ins();
      t_por();
      wrap_up();
   end
endmodule
